// File: rtl/vps_pkg.sv
// Package with register layout, reset values and types of the palette snoop.
package vps_pkg;

   // Register byte offset on the APB bus.
   localparam logic [11:0] VPS_REDIRECT_OFS = 12'h000;
   localparam logic [11:0] VPS_STATUS_OFS   = 12'h004;

   // Field positions of the redirect register.
   localparam int VPS_EN_BIT    = 31;
   localparam int VPS_MASK_LSB  = 0;
   localparam int VPS_ADDR_LSB  = 4;
   localparam int VPS_DATA_LSB  = 24;

   // Reset values of the redirect fields.
   localparam logic [3:0] VPS_MASK_RST = 4'h2;
   localparam logic [3:0] VPS_ADDR_RST = 4'h0;
   localparam logic [3:0] VPS_DATA_RST = 4'h1;
   localparam logic       VPS_EN_RST   = 1'b1;
   localparam logic [31:0] VPS_REDIRECT_RST = 32'h8100_0002;
   localparam logic [31:0] VPS_WMASK        = 32'h8f00_00ff;

   // Snooped palette I/O port addresses.
   localparam logic [15:0] VPS_PORT_MASK = 16'h03c6;
   localparam logic [15:0] VPS_PORT_ADDR = 16'h03c8;
   localparam logic [15:0] VPS_PORT_DATA = 16'h03c9;

   // Host I/O write seen on the bus.
   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
      logic [7:0]  data;
   } vps_io_wr_t;

   // Write cycle on the DAC host port.
   typedef struct packed {
      logic       wr;
      logic [3:0] addr;
      logic [7:0] data;
   } vps_dac_wr_t;

   typedef enum logic [1:0] {
      VPS_IDLE,
      VPS_ACCESS
   } vps_apb_st_t;

endpackage

// File: rtl/vps_palette_snoop.sv
// Palette write snoop, DAC host port redirect and pass-through video select.
`timescale 1ns/100ps
// Functional notes
// - Snoop palette writes only while enable set
// - Bits 3:0 redirect port 3C6, reset 2
// - Bits 7:4 redirect port 3C8, reset 0
// - Bits 27:24 redirect port 3C9, reset 1
// - One DAC write per snooped palette write
// - Pass-through selects external VGA pixel stream
module vps_palette_snoop
   import vps_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        reset,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Host I/O write indication from the PCI target logic.
   input  wire vps_io_wr_t  io_wr,
   // DAC host port write cycle.
   output vps_dac_wr_t      dac_wr,
   // Video streams.
   input  wire logic [7:0]  vga_pixel,
   input  wire logic [7:0]  native_pixel,
   output logic      [7:0]  lookup_pixel,
   output logic             pass_through
);

   logic [31:0] redirect_q;
   logic [31:0] redirect_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic        pready_q;
   logic        pslverr_q;
   logic        pslverr_d;
   vps_dac_wr_t dac_q;
   vps_dac_wr_t dac_d;
   logic [7:0]  pixel_q;
   logic [15:0] snoop_count_q;
   vps_apb_st_t st_q;
   vps_apb_st_t st_d;

   // Bus decode of the two words; everything else answers with an error.
   wire hit_redirect = paddr == VPS_REDIRECT_OFS;
   wire hit_status   = paddr == VPS_STATUS_OFS;
   wire hit_any      = hit_redirect || hit_status;
   wire access_now   = psel && penable && (st_q == VPS_ACCESS);
   wire do_write     = access_now && pwrite && hit_redirect;

   // Byte enables merged with the writable-bit mask; reserved bits stay 0.
   wire [31:0] lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                            {8{pstrb[1]}}, {8{pstrb[0]}}} & VPS_WMASK;
   assign redirect_d = do_write ?
      ((redirect_q & ~lane_mask) | (pwdata & lane_mask)) :
      redirect_q;

   // Split the register into its named fields.
   wire       snoop_en   = redirect_q[VPS_EN_BIT];
   wire [3:0] mask_port  = redirect_q[VPS_MASK_LSB +: 4];
   wire [3:0] addr_port  = redirect_q[VPS_ADDR_LSB +: 4];
   wire [3:0] data_port  = redirect_q[VPS_DATA_LSB +: 4];

   // Classify the host I/O write against the three palette ports.
   wire is_mask  = io_wr.addr == VPS_PORT_MASK;
   wire is_addr  = io_wr.addr == VPS_PORT_ADDR;
   wire is_data  = io_wr.addr == VPS_PORT_DATA;
   wire is_pal   = is_mask || is_addr || is_data;
   wire snoop_hit = io_wr.valid && is_pal && snoop_en;
   wire [3:0] redir_addr = is_mask ? mask_port :
                           is_addr ? addr_port : data_port;

   // One DAC write pulse per snooped write; the strobe is a single cycle.
   assign dac_d.wr   = snoop_hit;
   assign dac_d.addr = snoop_hit ? redir_addr : dac_q.addr;
   assign dac_d.data = snoop_hit ? io_wr.data : dac_q.data;

   // Read mux; status shows the enable and a count of snooped writes.
   wire [31:0] status_word = {15'h0000, snoop_en, snoop_count_q};
   assign prdata_d = (psel && !penable && !pwrite) ?
      (hit_redirect ? redirect_q : hit_status ? status_word : 32'h0000_0000)
      : prdata_q;
   assign pslverr_d = psel && !penable && !hit_any;

   // APB sequencing: setup latches read data, access completes in one cycle.
   always_comb begin
      st_d = st_q;
      case (st_q)
         VPS_IDLE: begin
            if (psel && !penable) begin
               st_d = VPS_ACCESS;
            end
         end
         VPS_ACCESS: begin
            st_d = VPS_IDLE;
         end
         default: begin
            st_d = VPS_IDLE;
         end
      endcase
   end

   // Bus-side registers; pready rises one cycle after setup.
   always_ff @(posedge mclk) begin
      if (reset) begin
         st_q      <= VPS_IDLE;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         st_q      <= st_d;
         pready_q  <= psel && !penable;
         pslverr_q <= pslverr_d;
         prdata_q  <= prdata_d;
      end
   end

   // Redirect register; reset gives a working pass-through with no firmware.
   always_ff @(posedge mclk) begin
      if (reset) begin
         redirect_q <= VPS_REDIRECT_RST;
      end else begin
         redirect_q <= redirect_d;
      end
   end

   // DAC port cycle and snoop counter, which wraps rather than saturates.
   always_ff @(posedge mclk) begin
      if (reset) begin
         dac_q         <= '0;
         snoop_count_q <= 16'h0000;
      end else begin
         dac_q <= dac_d;
         if (snoop_hit) begin
            snoop_count_q <= snoop_count_q + 16'h0001;
         end
      end
   end

   // Pixel select ahead of colour lookup, registered for a clean output.
   always_ff @(posedge mclk) begin
      if (reset) begin
         pixel_q <= 8'h00;
      end else begin
         pixel_q <= snoop_en ? vga_pixel : native_pixel;
      end
   end

   assign prdata       = prdata_q;
   assign pready       = pready_q;
   assign pslverr      = pslverr_q;
   assign dac_wr       = dac_q;
   assign lookup_pixel = pixel_q;
   assign pass_through = redirect_q[VPS_EN_BIT];

endmodule

// File: testbench/vps_host_model.sv
// Host model that issues VGA palette I/O writes.
`timescale 1ns/100ps
module vps_host_model
   import vps_pkg::*;
(
   input  wire logic mclk,
   output vps_io_wr_t io_wr
);
   initial io_wr = '0;
   // One-cycle write; afterwards the idle lines show the inverse.
   task automatic io_write(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      io_wr <= '{1'b1, a, d};
      @(posedge mclk);
      io_wr <= '{1'b0, ~a, ~d};
   endtask
endmodule

// File: testbench/vps_palette_snoop_chk.sv
// Checker for the palette snoop ports.
`timescale 1ns/100ps
module vps_chk
   import vps_pkg::*;
(
   input wire logic        mclk,
   input wire logic        reset,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic        pready,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire vps_io_wr_t  io_wr,
   input wire vps_dac_wr_t dac_wr,
   input wire logic [7:0]  vga_pixel,
   input wire logic [7:0]  lookup_pixel,
   input wire logic        pass_through
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   logic [31:0] sh_q;
   wire         on = sh_q[31];
   wire         hit = io_wr.valid && io_wr.addr inside
      {VPS_PORT_MASK, VPS_PORT_ADDR, VPS_PORT_DATA};
   wire         wr = psel && penable && pready && pwrite;
   // Shadow copy; it assumes full-word writes, as the bench makes.
   always_ff @(posedge mclk) begin
      if (reset)
         sh_q <= VPS_REDIRECT_RST;
      else if (wr && paddr == VPS_REDIRECT_OFS)
         sh_q <= pwdata & VPS_WMASK;
   end
   chk_en_mirror: assert property (pass_through == on)
      else $error("enable output differs");
   chk_mask_redir: assert property (io_wr.valid && on &&
      io_wr.addr == VPS_PORT_MASK |=> dac_wr.addr == $past(sh_q[3:0]))
      else $error("mask port address wrong");
   chk_addr_redir: assert property (io_wr.valid && on &&
      io_wr.addr == VPS_PORT_ADDR |=> dac_wr.addr == $past(sh_q[7:4]))
      else $error("address port address wrong");
   chk_data_redir: assert property (io_wr.valid && on &&
      io_wr.addr == VPS_PORT_DATA |=> dac_wr.addr == $past(sh_q[27:24]))
      else $error("data port address wrong");
   chk_one_write: assert property (hit && on |=> dac_wr.wr &&
      dac_wr.data == $past(io_wr.data)) else $error("write missing");
   chk_no_stray: assert property (dac_wr.wr |-> $past(hit && on))
      else $error("stray write");
   chk_off_quiet: assert property (io_wr.valid && !on |=> !dac_wr.wr)
      else $error("write while disabled");
   chk_video_sel: assert property (on |=>
      lookup_pixel == $past(vga_pixel)) else $error("video select");
   cover property (hit && on);
   cover property (io_wr.valid && !on);
   cover property (wr);
endmodule
bind vps_palette_snoop vps_chk i_vps_chk (.mclk(mclk), .reset(reset),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
   .paddr(paddr), .pwdata(pwdata), .io_wr(io_wr), .dac_wr(dac_wr),
   .vga_pixel(vga_pixel), .lookup_pixel(lookup_pixel),
   .pass_through(pass_through));

// File: testbench/vps_palette_snoop_tb_top.sv
// Self-checking bench for the palette snoop block.
`timescale 1ns/100ps
module vps_palette_snoop_tb_top
   import vps_pkg::*;
;
   logic        mclk = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, r;
   logic        pready, pslverr, pass_through, e;
   logic [7:0]  lookup_pixel;
   vps_io_wr_t  io_wr;
   vps_dac_wr_t dac_wr;
   int          miscompares = 0;
   int          samples_checked = 0;
   logic [15:0] pt [4] = '{VPS_PORT_MASK, VPS_PORT_ADDR, VPS_PORT_DATA,
                           16'h03c7};
   always #5 mclk = ~mclk;
   vps_host_model i_vps_host_model (.mclk(mclk), .io_wr(io_wr));
   vps_palette_snoop i_vps_palette_snoop (.mclk(mclk), .reset(reset),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .io_wr(io_wr), .dac_wr(dac_wr),
      .vga_pixel(8'h5a), .native_pixel(8'ha5),
      .lookup_pixel(lookup_pixel), .pass_through(pass_through));
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      samples_checked++;
      if (g !== x) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic wrap_up();
      if (miscompares == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Holds the request until pready is seen at a rising edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Stray port 3c7 sits last, so it must never give a DAC write.
   task automatic snoop(input logic [31:0] v);
      logic [3:0] f;
      for (int i = 0; i < 4; i++) begin
         f = i == 0 ? v[3:0] : i == 1 ? v[7:4] : v[27:24];
         i_vps_host_model.io_write(pt[i], pt[i][7:0]);
         #1;
         chk("dac_wr.wr", 32'(v[31] && i < 3), 32'(dac_wr.wr));
         if (v[31] && i < 3)
            chk("dac_wr", {f, pt[i][7:0]}, {dac_wr.addr, dac_wr.data});
      end
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      reset <= 1'b0;
      apb(1'b0, VPS_REDIRECT_OFS, '0);
      chk("redirect", VPS_REDIRECT_RST, r);
      chk("lookup", 32'h5a, 32'(lookup_pixel));
      snoop(VPS_REDIRECT_RST);
      apb(1'b1, VPS_REDIRECT_OFS, 32'hffff_ffff);
      apb(1'b0, VPS_REDIRECT_OFS, '0);
      chk("redirect", VPS_WMASK, r);
      apb(1'b1, VPS_REDIRECT_OFS, 32'h8300_0054);
      snoop(32'h8300_0054);
      apb(1'b1, VPS_REDIRECT_OFS, 32'h0300_0054);
      snoop(32'h0300_0054);
      chk("pass_through", '0, 32'(pass_through));
      chk("lookup", 32'ha5, 32'(lookup_pixel));
      apb(1'b0, 12'h008, '0);
      chk("pslverr", 32'h1, 32'(e));
      chk("unmapped", '0, r);
      apb(1'b0, VPS_STATUS_OFS, '0);
      chk("status", 32'h0000_0006, r);
      wrap_up();
   end
   // Watchdog well beyond the roughly 70 cycles the tests take.
   initial begin
      repeat (5000) @(posedge mclk);
      miscompares++;
      wrap_up();
   end
endmodule
